/* logic/spe_defs.svh */
// Contract
// RL1: transmit-empty flag at 1 raises the transmit-empty request, usable by DMA.
// RL2: transmit-end request only in normal mode with flag and its enable both 1.
// RL3: receive-full flag at 1 raises the receive-full request, usable by DMA.
// RL4: overrun, parity or framing flag raises error request; error and end never DMA.
// RL5: own code and enable per request (error and full requests share rx_irq_enable); DMA moves clear empty and full flags.
// RL6: priority error, full, empty, end; empty wins over end.
// RL7: smart-card: no end request; error from overrun, parity or error-signal flags.
// RL8: smart-card frame success sets end and empty flags together.
// RL9: smart-card error signal resends same byte, end flag stays 0.
// RL10: error-signal flag never cleared by hardware; software clears it. Here stop or standby also clears it with the status reset.
// RL11: smart-card receive error sets error flag, leaves full flag unset.
// RL12: transfer controller is set up before the serial unit.
// RL13: after reset module stopped; registers usable only after stop released.
// RL14: receiver keeps running in a break; framing flag sets again.
// RL15: transmit disabled: pin driven from port data and direction.
// RL16: clearing transmit enable aborts the frame at once.
// RL17: synchronous mode: no transmit start while receive error flags set.
// RL18: move from buffer to shifter sets transmit-empty flag. Here smart-card mode sets it only at frame success.
// RL19: buffer writes always accepted; write while not empty overwrites.
// RL20: external clock waits five cycles after DMA buffer update.
// RL21: stop or standby resets transmit shifter, buffer, status; pin high after.
// RL22: stop or standby resets receive shifter, buffer and status.
// RL23: software clears enables before stop and follows resume sequence.
// RL24: requests are levels while flag and enable both 1.
// RL25: smart-card error signal sets error-signal flag; error request if enabled.
// RL26: smart-card parity error keeps data in receive buffer, full flag unset.
`ifndef SPE_DEFS_SVH
`define SPE_DEFS_SVH
`define SPE_CTRL_OFS 8'h00
`define SPE_STATUS_OFS 8'h04
`define SPE_TXBUF_OFS 8'h08
`define SPE_RXBUF_OFS 8'h0c
`define SPE_PORT_OFS 8'h10
`define SPE_MSTOP_OFS 8'h14
`define SPE_PRIO_OFS 8'h18
`define SPE_STATUS_RST 7'h03
`define SPE_MSTOP_RST 1'b1
`endif

/* logic/spe_pkg.sv */
package spe_pkg;
    // highest pending request, in priority order
    typedef enum logic [2:0] {SPE_REQ_NONE, SPE_REQ_ERR, SPE_REQ_RXF, SPE_REQ_TXE,
        SPE_REQ_TXEND} spe_req_t;
    // control bits: ctrl register bits 6..0 in this order from msb
    typedef struct packed {
        logic sync_mode;
        logic smart_mode;
        logic rx_enable_bit;
        logic tx_enable_bit;
        logic tx_end_irq_enable;
        logic rx_irq_enable;
        logic tx_irq_enable;
    } spe_ctrl_t;
    // status flags: status register bits 6..0 in this order from msb
    typedef struct packed {
        logic error_signal_flag;
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_flag;
        logic rx_buffer_full_flag;
        logic tx_end_flag;
        logic tx_buffer_empty_flag;
    } spe_flags_t;
    typedef struct packed {
        spe_ctrl_t ctrl;
        spe_flags_t flags;
        logic mstop;
        logic port_data_reg;
        logic port_dir;
        logic [7:0] tx_buffer;
        logic [7:0] tx_shift_reg;
        logic tx_busy;
        logic tx_load;
        logic [7:0] rx_buffer;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic rx_error_request;
        logic rx_full_request;
        logic tx_empty_request;
        logic tx_end_request;
        spe_req_t top_req;
        logic txd_out;
        logic txd_oe;
    } spe_state_t;
endpackage

/* logic/spe_top.sv */
// Implementation choices: the placing of the registers and register access over APB.
`include "spe_defs.svh"
module spe_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power control
    input wire logic standby,
    // frame engine side
    input wire logic tx_frame_done,
    input wire logic tx_error_sig,
    input wire logic tx_serial_bit,
    output logic tx_load,
    output logic [7:0] tx_shift_data,
    input wire logic rx_frame_done,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_bad,
    input wire logic rx_stop_bad,
    // transfer controller side
    input wire logic dma_tx_write,
    input wire logic [7:0] dma_tx_data,
    input wire logic dma_rx_read,
    output logic [7:0] dma_rx_data,
    // request outputs
    output logic rx_error_request,
    output logic rx_full_request,
    output logic tx_empty_request,
    output logic tx_end_request,
    output spe_pkg::spe_req_t top_req,
    // transmit pin
    output logic txd_out,
    output logic txd_oe
);
    import spe_pkg::*;

    spe_state_t st_ff;
    spe_state_t nxt_st;
    logic stopped;
    logic setup_ph;
    logic wr_acc;
    logic err_any;
    logic tx_start;

    assign stopped = st_ff.mstop | standby;
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & st_ff.pready & pwrite & ~st_ff.pslverr;

    // next state of everything
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tx_load = 1'b0;
        nxt_st.pready = 1'b0;
        // apb setup: latch read data and answer in the access phase
        if (setup_ph)
        begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata = 32'h0;
            if (paddr == `SPE_MSTOP_OFS)
                nxt_st.prdata = {31'h0, st_ff.mstop};
            else if (stopped)
                nxt_st.pslverr = 1'b1; // see RL13
            else if (paddr == `SPE_CTRL_OFS)
                nxt_st.prdata = {25'h0, st_ff.ctrl};
            else if (paddr == `SPE_STATUS_OFS)
                nxt_st.prdata = {25'h0, st_ff.flags};
            else if (paddr == `SPE_TXBUF_OFS)
                nxt_st.prdata = {24'h0, st_ff.tx_buffer};
            else if (paddr == `SPE_RXBUF_OFS)
                nxt_st.prdata = {24'h0, st_ff.rx_buffer};
            else if (paddr == `SPE_PORT_OFS)
                nxt_st.prdata = {30'h0, st_ff.port_dir, st_ff.port_data_reg};
            else if (paddr == `SPE_PRIO_OFS)
                nxt_st.prdata = {29'h0, st_ff.top_req};
            else
                nxt_st.pslverr = 1'b1;
        end
        // apb writes take effect at the completing edge
        if (wr_acc)
        begin
            if (paddr == `SPE_MSTOP_OFS)
                nxt_st.mstop = pwdata[0];
            else if (paddr == `SPE_CTRL_OFS)
                nxt_st.ctrl = pwdata[6:0];
            else if (paddr == `SPE_STATUS_OFS)
            begin
                // write 0 clears; clearing empty also clears end
                nxt_st.flags = st_ff.flags & pwdata[6:0]; // see RL10
                if (!pwdata[0])
                    nxt_st.flags.tx_end_flag = 1'b0;
            end
            else if (paddr == `SPE_TXBUF_OFS)
                nxt_st.tx_buffer = pwdata[7:0]; // see RL19
            else if (paddr == `SPE_PORT_OFS)
            begin
                nxt_st.port_data_reg = pwdata[0];
                nxt_st.port_dir = pwdata[1];
            end
        end
        // dma moves clear their flags; sets below still win
        if (dma_tx_write && !stopped)
        begin
            nxt_st.tx_buffer = dma_tx_data;
            nxt_st.flags.tx_buffer_empty_flag = 1'b0; // see RL5
            nxt_st.flags.tx_end_flag = 1'b0;
        end
        if (dma_rx_read && !stopped)
            nxt_st.flags.rx_buffer_full_flag = 1'b0; // see RL5
        // transmitter
        if (!st_ff.ctrl.tx_enable_bit)
            nxt_st.tx_busy = 1'b0; // see RL16
        else if (st_ff.tx_busy && tx_frame_done)
        begin
            if (st_ff.ctrl.smart_mode && tx_error_sig)
            begin
                nxt_st.flags.error_signal_flag = 1'b1; // see RL25
                nxt_st.tx_load = 1'b1; // see RL9
            end
            else
            begin
                nxt_st.tx_busy = 1'b0;
                if (st_ff.ctrl.smart_mode)
                begin
                    nxt_st.flags.tx_end_flag = 1'b1; // see RL8
                    nxt_st.flags.tx_buffer_empty_flag = 1'b1;
                end
                else if (st_ff.flags.tx_buffer_empty_flag)
                    nxt_st.flags.tx_end_flag = 1'b1;
            end
        end
        else if (tx_start)
        begin
            nxt_st.tx_shift_reg = st_ff.tx_buffer;
            nxt_st.tx_busy = 1'b1;
            nxt_st.tx_load = 1'b1;
            nxt_st.flags.tx_end_flag = 1'b0;
            // smart-card keeps empty low until the frame is acknowledged
            if (!st_ff.ctrl.smart_mode)
                nxt_st.flags.tx_buffer_empty_flag = 1'b1; // see RL18
        end
        // receiver keeps running through a break
        if (rx_frame_done && st_ff.ctrl.rx_enable_bit && !stopped)
        begin
            if (st_ff.flags.rx_buffer_full_flag)
                nxt_st.flags.overrun_flag = 1'b1;
            else
            begin
                nxt_st.rx_buffer = rx_data; // see RL26
                if (rx_parity_bad)
                    nxt_st.flags.parity_error_flag = 1'b1;
                if (rx_stop_bad && !st_ff.ctrl.smart_mode)
                    nxt_st.flags.framing_error_flag = 1'b1; // see RL14
                if (!rx_parity_bad && !(rx_stop_bad && !st_ff.ctrl.smart_mode))
                    nxt_st.flags.rx_buffer_full_flag = 1'b1; // see RL11
            end
        end
        // stop or standby resets shifters, buffers and status
        if (stopped)
        begin
            nxt_st.flags = `SPE_STATUS_RST; // see RL21
            nxt_st.tx_buffer = 8'h00;
            nxt_st.tx_shift_reg = 8'h00;
            nxt_st.tx_busy = 1'b0;
            nxt_st.tx_load = 1'b0;
            nxt_st.rx_buffer = 8'h00; // see RL22
        end
        // request levels from current flags and enables
        nxt_st.rx_error_request = err_any & st_ff.ctrl.rx_irq_enable; // see RL4
        nxt_st.rx_full_request = st_ff.flags.rx_buffer_full_flag // see RL24
            & st_ff.ctrl.rx_irq_enable; // see RL3
        nxt_st.tx_empty_request = st_ff.flags.tx_buffer_empty_flag
            & st_ff.ctrl.tx_irq_enable; // see RL1
        nxt_st.tx_end_request = st_ff.flags.tx_end_flag & st_ff.ctrl.tx_end_irq_enable
            & ~st_ff.ctrl.smart_mode; // see RL2
        // priority encoder
        if (nxt_st.rx_error_request)
            nxt_st.top_req = SPE_REQ_ERR; // see RL6
        else if (nxt_st.rx_full_request)
            nxt_st.top_req = SPE_REQ_RXF;
        else if (nxt_st.tx_empty_request)
            nxt_st.top_req = SPE_REQ_TXE;
        else if (nxt_st.tx_end_request)
            nxt_st.top_req = SPE_REQ_TXEND;
        else
            nxt_st.top_req = SPE_REQ_NONE;
        // pin: serial data when enabled, else port logic; idle high while stopped
        if (stopped)
        begin
            nxt_st.txd_out = 1'b1; // see RL21
            nxt_st.txd_oe = st_ff.port_dir;
        end
        else if (st_ff.ctrl.tx_enable_bit && st_ff.tx_busy)
        begin
            nxt_st.txd_out = tx_serial_bit;
            nxt_st.txd_oe = 1'b1;
        end
        else if (st_ff.ctrl.tx_enable_bit)
        begin
            nxt_st.txd_out = 1'b1;
            nxt_st.txd_oe = 1'b1;
        end
        else
        begin
            nxt_st.txd_out = st_ff.port_data_reg; // see RL15
            nxt_st.txd_oe = st_ff.port_dir;
        end
    end

    // error sources differ by mode; the error-signal flag only counts in smart-card
    always_comb
    begin
        if (st_ff.ctrl.smart_mode)
            err_any = st_ff.flags.overrun_flag | st_ff.flags.parity_error_flag
                | st_ff.flags.error_signal_flag; // see RL7
        else
            err_any = st_ff.flags.overrun_flag | st_ff.flags.parity_error_flag
                | st_ff.flags.framing_error_flag;
    end

    // start needs pending data; synchronous mode is blocked by receive errors
    assign tx_start = st_ff.ctrl.tx_enable_bit & ~st_ff.tx_busy & ~stopped
        & ~st_ff.flags.tx_buffer_empty_flag
        & ~(st_ff.ctrl.sync_mode & (st_ff.flags.overrun_flag
        | st_ff.flags.framing_error_flag | st_ff.flags.parity_error_flag)); // see RL17

    // the one state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.mstop <= `SPE_MSTOP_RST; // see RL13
            st_ff.flags <= `SPE_STATUS_RST;
            st_ff.txd_out <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign tx_load = st_ff.tx_load;
    assign tx_shift_data = st_ff.tx_shift_reg;
    assign dma_rx_data = st_ff.rx_buffer;
    assign rx_error_request = st_ff.rx_error_request;
    assign rx_full_request = st_ff.rx_full_request;
    assign tx_empty_request = st_ff.tx_empty_request;
    assign tx_end_request = st_ff.tx_end_request;
    assign top_req = st_ff.top_req;
    assign txd_out = st_ff.txd_out;
    assign txd_oe = st_ff.txd_oe;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // request levels and their priority
    a_empty_req_level: assert property ((st_ff.flags.tx_buffer_empty_flag // see RL1
        && st_ff.ctrl.tx_irq_enable) |=> tx_empty_request)
        else $error("empty request missing");

    a_end_req_smart: assert property (st_ff.ctrl.smart_mode |=> !tx_end_request) // see RL2
        else $error("end request in smart mode");

    a_full_req_level: assert property ((st_ff.flags.rx_buffer_full_flag // see RL3
        && st_ff.ctrl.rx_irq_enable) |=> rx_full_request)
        else $error("full request missing");

    a_err_prio_top: assert property (rx_error_request |-> top_req == SPE_REQ_ERR) // see RL6
        else $error("error not top priority");

    a_txe_over_end: assert property ((tx_empty_request && tx_end_request // see RL6
        && !rx_full_request && !rx_error_request) |-> top_req == SPE_REQ_TXE)
        else $error("end beat empty");

    a_dma_rx_clear: assert property ((dma_rx_read && !stopped && !rx_frame_done) // see RL5
        |=> !st_ff.flags.rx_buffer_full_flag)
        else $error("dma read left full flag");

    a_ers_sticky: assert property ((st_ff.flags.error_signal_flag && !wr_acc // see RL10
        && !stopped) |=> st_ff.flags.error_signal_flag)
        else $error("error-signal flag lost");

    // smart-card frame endings
    a_smart_pair: assert property ((st_ff.ctrl.smart_mode && !tx_error_sig // see RL8
        && st_ff.ctrl.tx_enable_bit && st_ff.tx_busy && tx_frame_done)
        |=> st_ff.flags.tx_end_flag && st_ff.flags.tx_buffer_empty_flag)
        else $error("end and empty apart");

    a_smart_resend: assert property ((st_ff.ctrl.smart_mode && tx_error_sig // see RL9
        && st_ff.ctrl.tx_enable_bit && st_ff.tx_busy && tx_frame_done && !stopped)
        |=> tx_load && !st_ff.flags.tx_end_flag)
        else $error("no resend on error");

    a_smart_par_full: assert property ((st_ff.ctrl.smart_mode && rx_parity_bad // see RL11
        && rx_frame_done && st_ff.ctrl.rx_enable_bit && !stopped
        && !st_ff.flags.rx_buffer_full_flag) |=> !st_ff.flags.rx_buffer_full_flag)
        else $error("parity frame marked full");

    a_te_abort: assert property (!st_ff.ctrl.tx_enable_bit |=> !st_ff.tx_busy) // see RL16
        else $error("transmitter not aborted");

    a_sync_block: assert property ((st_ff.ctrl.sync_mode && !st_ff.tx_busy // see RL17
        && (st_ff.flags.overrun_flag || st_ff.flags.framing_error_flag
        || st_ff.flags.parity_error_flag)) |=> !st_ff.tx_busy)
        else $error("sync start despite error");

    a_load_sets_empty: assert property ((tx_start && !st_ff.ctrl.smart_mode) // see RL18
        |=> st_ff.flags.tx_buffer_empty_flag && tx_load)
        else $error("load did not set empty");

    a_stop_resets: assert property (stopped |=> st_ff.flags == `SPE_STATUS_RST // see RL21
        && !st_ff.tx_busy)
        else $error("stop did not reset");

    a_port_pin: assert property ((!st_ff.ctrl.tx_enable_bit && !stopped) // see RL15
        |=> txd_out == $past(st_ff.port_data_reg))
        else $error("pin not from port");

    a_stopped_err: assert property ((setup_ph && stopped && paddr != `SPE_MSTOP_OFS) // see RL13
        |=> pready && pslverr)
        else $error("access while stopped");

    // main scenarios reached
    c_smart_resend: cover property (st_ff.ctrl.smart_mode && tx_frame_done && tx_error_sig
        && st_ff.tx_busy);

    c_overrun: cover property (rx_frame_done && st_ff.flags.rx_buffer_full_flag);

    c_dma_tx: cover property (tx_empty_request ##1 dma_tx_write);

    c_end_req: cover property (tx_end_request && !tx_empty_request);
endmodule

/* sim/spe_far_end.sv */
module spe_far_end #(
    parameter int FRAME_LEN = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // frame engine pins of the block
    input wire logic tx_load,
    input wire logic [7:0] tx_shift_data,
    output logic tx_frame_done,
    output logic tx_error_sig,
    output logic tx_serial_bit,
    output logic rx_frame_done,
    output logic [7:0] rx_data,
    output logic rx_parity_bad,
    output logic rx_stop_bad,
    // bench commands
    input wire logic err_next,
    input wire logic rx_go,
    input wire logic [7:0] rx_byte,
    input wire logic [1:0] rx_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shreg, last_byte, rx_hold;
    logic [1:0] bad_hold;
    logic busy, tgl;
    int cnt, loads, frames;
    // frame lasts well over five cycles after each load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            tgl <= 1'b0;
            cnt <= 0;
            loads <= 0;
            frames <= 0;
            tx_frame_done <= 1'b0;
            rx_frame_done <= 1'b0;
        end
        else
        begin
            tgl <= ~tgl;
            tx_frame_done <= 1'b0;
            rx_frame_done <= rx_go;
            if (rx_go)
            begin
                rx_hold <= rx_byte;
                bad_hold <= rx_bad;
            end
            if (tx_load)
            begin
                busy <= 1'b1;
                cnt <= 0;
                shreg <= tx_shift_data;
                last_byte <= tx_shift_data;
                loads <= loads + 1;
            end
            else if (busy)
            begin
                cnt <= cnt + 1;
                if (cnt == FRAME_LEN - 1)
                begin
                    busy <= 1'b0;
                    tx_frame_done <= 1'b1;
                    frames <= frames + 1;
                end
            end
        end
    end
    // outside a frame the lines change every cycle, never a stale value
    assign tx_serial_bit = busy ? shreg[cnt[2:0]] : tgl;
    assign tx_error_sig = tx_frame_done ? err_next : tgl;
    assign rx_data = rx_frame_done ? rx_hold : {8{tgl}};
    assign rx_parity_bad = rx_frame_done ? bad_hold[0] : tgl;
    assign rx_stop_bad = rx_frame_done ? bad_hold[1] : tgl;
endmodule

/* sim/tb_top.sv */
`include "spe_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spe_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
    logic [7:0] paddr = 8'h00, dma_tx_data = 8'h00, rx_byte = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, tx_frame_done, tx_error_sig, tx_serial_bit, tx_load;
    logic [7:0] tx_shift_data, rx_data, dma_rx_data;
    logic rx_frame_done, rx_parity_bad, rx_stop_bad, txd_out, txd_oe;
    logic dma_tx_write = 1'b0, dma_rx_read = 1'b0, err_next = 1'b0, rx_go = 1'b0;
    logic [1:0] rx_bad = 2'b00;
    logic rx_error_request, rx_full_request, tx_empty_request, tx_end_request;
    spe_req_t top_req;
    int mismatches = 0, checks_done = 0, cycles = 0, n0;
    spe_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby(standby), .tx_frame_done(tx_frame_done),
        .tx_error_sig(tx_error_sig), .tx_serial_bit(tx_serial_bit), .tx_load(tx_load),
        .tx_shift_data(tx_shift_data), .rx_frame_done(rx_frame_done), .rx_data(rx_data),
        .rx_parity_bad(rx_parity_bad), .rx_stop_bad(rx_stop_bad),
        .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read),
        .dma_rx_data(dma_rx_data), .rx_error_request(rx_error_request),
        .rx_full_request(rx_full_request), .tx_empty_request(tx_empty_request),
        .tx_end_request(tx_end_request), .top_req(top_req), .txd_out(txd_out),
        .txd_oe(txd_oe));
    spe_far_end #(.FRAME_LEN(8)) far (.pclk(pclk), .presetn(presetn), .tx_load(tx_load),
        .tx_shift_data(tx_shift_data), .tx_frame_done(tx_frame_done),
        .tx_error_sig(tx_error_sig), .tx_serial_bit(tx_serial_bit),
        .rx_frame_done(rx_frame_done), .rx_data(rx_data), .rx_parity_bad(rx_parity_bad),
        .rx_stop_bad(rx_stop_bad), .err_next(err_next), .rx_go(rx_go), .rx_byte(rx_byte),
        .rx_bad(rx_bad));
    // 20 ns clock
    always #10 pclk = ~pclk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
        apb(1'b0, a, 32'h0);
        chk(w, rdat, e);
    endtask
    task automatic dma_w(input logic [7:0] b);
        dma_tx_write <= 1'b1;
        dma_tx_data <= b;
        @(posedge pclk);
        dma_tx_write <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rx_send(input logic [7:0] b, input logic [1:0] bad);
        rx_go <= 1'b1;
        rx_byte <= b;
        rx_bad <= bad;
        @(posedge pclk);
        rx_go <= 1'b0;
        tick(3);
    endtask
    task automatic wait_frames();
        int f0, k;
        f0 = far.frames;
        k = 0;
        while (far.frames == f0 && k < 100)
        begin
            @(posedge pclk);
            k++;
        end
    endtask
    task automatic t_reset();
        apb(1'b0, `SPE_STATUS_OFS, 32'h0);
        chk("stopped access refused", {rerr, rdat}, 33'h1_0000_0000);
        rd(`SPE_MSTOP_OFS, 32'h1, "mstop at reset");
        apb(1'b1, `SPE_MSTOP_OFS, 32'h0);
        rd(`SPE_STATUS_OFS, 32'h03, "status at reset");
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped refused", rerr, 1'b1);
    endtask
    task automatic t_tx_normal();
        apb(1'b1, `SPE_CTRL_OFS, 32'h0d);
        tick(2);
        chk("empty request", tx_empty_request, 1'b1);
        chk("end request", tx_end_request, 1'b1);
        chk("empty before end", top_req, SPE_REQ_TXE);
        n0 = far.loads;
        dma_w(8'ha5);
        tick(2);
        chk("dma byte loaded", {far.last_byte, 24'(far.loads - n0)}, {8'ha5, 24'h1});
        rd(`SPE_STATUS_OFS, 32'h01, "empty set at load");
        chk("end request dropped", tx_end_request, 1'b0);
        wait_frames();
        tick(2);
        rd(`SPE_STATUS_OFS, 32'h03, "end after frame");
    endtask
    task automatic t_tx_port();
        apb(1'b1, `SPE_CTRL_OFS, 32'h01);
        apb(1'b1, `SPE_TXBUF_OFS, 32'h11);
        apb(1'b1, `SPE_TXBUF_OFS, 32'h22);
        apb(1'b1, `SPE_STATUS_OFS, 32'h0);
        tick(2);
        chk("empty request low", tx_empty_request, 1'b0);
        apb(1'b1, `SPE_PORT_OFS, 32'h2);
        apb(1'b1, `SPE_CTRL_OFS, 32'h09);
        tick(2);
        chk("overwritten byte", far.last_byte, 8'h22);
        apb(1'b1, `SPE_CTRL_OFS, 32'h01);
        tick(2);
        chk("break on pin", {txd_oe, txd_out}, 2'b10);
        apb(1'b1, `SPE_PORT_OFS, 32'h3);
        tick(2);
        chk("mark on pin", {txd_oe, txd_out}, 2'b11);
        wait_frames();
    endtask
    task automatic t_rx_normal();
        apb(1'b1, `SPE_STATUS_OFS, 32'h0);
        apb(1'b1, `SPE_CTRL_OFS, 32'h12);
        rx_send(8'h3c, 2'b00);
        chk("full request", {rx_full_request, 29'(top_req)}, {1'b1, 29'(SPE_REQ_RXF)});
        dma_rx_read <= 1'b1;
        @(posedge pclk);
        dma_rx_read <= 1'b0;
        tick(2);
        chk("dma read data", {dma_rx_data, rx_full_request}, {8'h3c, 1'b0});
        rx_send(8'h01, 2'b00);
        rx_send(8'h02, 2'b00);
        chk("overrun request", {rx_error_request, 29'(top_req)}, {1'b1, 29'(SPE_REQ_ERR)});
        rd(`SPE_STATUS_OFS, 32'h0c, "overrun flags");
        apb(1'b1, `SPE_STATUS_OFS, 32'h0);
        rx_send(8'h00, 2'b10);
        apb(1'b1, `SPE_STATUS_OFS, 32'h0);
        rx_send(8'h00, 2'b10);
        rd(`SPE_STATUS_OFS, 32'h10, "framing set again");
        chk("framing request", rx_error_request, 1'b1);
    endtask
    task automatic t_sync_block();
        apb(1'b1, `SPE_CTRL_OFS, 32'h48);
        n0 = far.loads;
        dma_w(8'h5a);
        tick(4);
        chk("no start on error", far.loads, n0);
        rd(`SPE_STATUS_OFS, 32'h10, "error kept");
        apb(1'b1, `SPE_STATUS_OFS, 32'h0);
        tick(3);
        chk("start after clear", far.loads, n0 + 1);
        wait_frames();
    endtask
    task automatic t_smart();
        apb(1'b1, `SPE_CTRL_OFS, 32'h2f);
        err_next <= 1'b1;
        n0 = far.loads;
        dma_w(8'h77);
        wait_frames();
        tick(3);
        err_next <= 1'b0;
        rd(`SPE_STATUS_OFS, 32'h40, "end stays low");
        chk("same byte resent", {far.last_byte, 24'(far.loads - n0)}, {8'h77, 24'h2});
        chk("error signal request", rx_error_request, 1'b1);
        wait_frames();
        tick(3);
        rd(`SPE_STATUS_OFS, 32'h43, "end and empty together");
        chk("no end request", {tx_end_request, tx_empty_request}, 2'b01);
        rd(`SPE_PRIO_OFS, 32'(SPE_REQ_ERR), "prio register");
        apb(1'b1, `SPE_STATUS_OFS, 32'h3f);
        rd(`SPE_STATUS_OFS, 32'h03, "error signal cleared");
        apb(1'b1, `SPE_CTRL_OFS, 32'h32);
        apb(1'b1, `SPE_STATUS_OFS, 32'h0);
        rx_send(8'h96, 2'b01);
        rd(`SPE_STATUS_OFS, 32'h20, "parity without full");
        chk("parity request", {rx_error_request, rx_full_request}, 2'b10);
        rd(`SPE_RXBUF_OFS, 32'h96, "parity data kept");
    endtask
    task automatic t_standby();
        apb(1'b1, `SPE_CTRL_OFS, 32'h0);
        standby <= 1'b1;
        tick(3);
        chk("pin high in standby", txd_out, 1'b1);
        apb(1'b0, `SPE_STATUS_OFS, 32'h0);
        chk("standby refused", rerr, 1'b1);
        standby <= 1'b0;
        tick(2);
        rd(`SPE_STATUS_OFS, 32'h03, "status after standby");
        rd(`SPE_RXBUF_OFS, 32'h00, "rx buffer after standby");
    endtask
    // main sequence
    initial
    begin
        tick(4);
        presetn <= 1'b1;
        t_reset();
        t_tx_normal();
        t_tx_port();
        t_rx_normal();
        t_sync_block();
        t_smart();
        t_standby();
        stop_test();
    end
endmodule
